// ### dio_params.svh
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

// Channel counts and field widths
`define DIO_NUM_IN 8
`define DIO_NUM_RELAY 5
`define DIO_MV_W 19
`define DIO_THR_W 12
`define DIO_DLY_W 21
`define DIO_ELAPSED_W 22
`define DIO_CNT_W 32

// Timing: clock rate, millisecond tick and scan period
`define DIO_CLK_HZ 20000000
`define DIO_MS_TIME_US 1000
`define DIO_MS_CYCLES (`DIO_MS_TIME_US * (`DIO_CLK_HZ / 1000000))
`define DIO_SCAN_TIME_MS 5
`define DIO_AC_DROP_MS 30

// Threshold scaling: 0.1 V steps against millivolt samples, AC release at 10 %
`define DIO_THR_MV_STEP 100
`define DIO_AC_REL_DIV 10

// Reset values of the settings
`define DIO_ACT_THR_RST 12'h370
`define DIO_REL_THR_RST 12'h258
`define DIO_DLY_RST 21'h0

// Register map: global words and per-channel pages
`define DIO_RELAY_OFS 12'h000
`define DIO_STATUS_OFS 12'h004
`define DIO_CLEAR_OFS 12'h008
`define DIO_CH_PAGE 4'h1
`define DIO_CH_CFG 3'h0
`define DIO_CH_ACT 3'h1
`define DIO_CH_REL 3'h2
`define DIO_CH_ADLY 3'h3
`define DIO_CH_DDLY 3'h4
`define DIO_CH_CNT 3'h5
`define DIO_CH_VOLT 3'h6
`define DIO_CFG_POL_BIT 0
`define DIO_CFG_AC_BIT 1

// Bus responses
`define DIO_RESP_OKAY 2'h0
`define DIO_RESP_SLVERR 2'h2

`endif

// ### dio_pkg.sv
package dio_pkg;
`include "dio_params.svh"

	typedef logic [`DIO_MV_W-1:0] mv_t;
	typedef logic [`DIO_THR_W-1:0] thr_t;
	typedef logic [`DIO_DLY_W-1:0] dly_t;
	typedef logic [`DIO_ELAPSED_W-1:0] elapsed_t;
	typedef logic [`DIO_CNT_W-1:0] cnt_t;

	typedef enum logic [0:0] {WR_COLLECT, WR_RESP} wr_state_t;
	typedef enum logic [0:0] {RD_IDLE, RD_DATA} rd_state_t;

	// Per-channel conditioning state
	typedef struct packed {
		logic energized;
		logic raw;
		logic status;
		elapsed_t elapsed;
		cnt_t count;
	} chan_state_t;

	// Scan timer state
	typedef struct packed {
		logic [19:0] ms_cnt;
		logic [2:0] scan_cnt;
		logic ms_tick;
		logic scan_tick;
	} timer_state_t;

	// Bus slave and settings state
	typedef struct packed {
		wr_state_t wr;
		logic aw_have;
		logic w_have;
		logic awready;
		logic wready;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		rd_state_t rd;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [`DIO_NUM_RELAY-1:0] relay_cmd;
		logic [`DIO_NUM_RELAY-1:0] relay_out;
		logic [`DIO_NUM_IN-1:0] clear;
		logic [`DIO_NUM_IN-1:0] pol;
		logic [`DIO_NUM_IN-1:0] ac;
		logic [`DIO_NUM_IN-1:0][`DIO_THR_W-1:0] act_thr;
		logic [`DIO_NUM_IN-1:0][`DIO_THR_W-1:0] rel_thr;
		logic [`DIO_NUM_IN-1:0][`DIO_DLY_W-1:0] act_dly;
		logic [`DIO_NUM_IN-1:0][`DIO_DLY_W-1:0] drop_dly;
	} regs_t;

	// Threshold in 0.1 V steps to millivolts
	function automatic mv_t thr_to_mv(input thr_t thr);
		return mv_t'({7'h0, thr} * mv_t'(`DIO_THR_MV_STEP));
	endfunction

endpackage

// ### scan_timer.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module scan_timer #(
	parameter int unsigned MS_CYCLES = `DIO_MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Ticks, one cycle each
	output logic ms_tick,
	output logic scan_tick
);

	dio_pkg::timer_state_t q, d;

	// Millisecond divider, and every fifth millisecond a scan
	always_comb begin
		d = q;
		d.ms_tick = 1'b0;
		d.scan_tick = 1'b0;
		if (q.ms_cnt == 20'(MS_CYCLES - 1)) begin
			d.ms_cnt = '0;
			d.ms_tick = 1'b1;
			if (q.scan_cnt == 3'(`DIO_SCAN_TIME_MS - 1)) begin
				d.scan_cnt = '0;
				d.scan_tick = 1'b1;
			end else begin
				d.scan_cnt = q.scan_cnt + 3'h1;
			end
		end else begin
			d.ms_cnt = q.ms_cnt + 20'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ms_tick = q.ms_tick;
	assign scan_tick = q.scan_tick;

endmodule

// ### input_channel_cond.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module input_channel_cond (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Timing ticks
	input wire logic ms_tick,
	input wire logic scan_tick,
	// Settings
	input wire logic energized_inactive,
	input wire logic ac_mode,
	input wire dio_pkg::thr_t act_thr,
	input wire dio_pkg::thr_t rel_thr,
	input wire dio_pkg::dly_t act_dly,
	input wire dio_pkg::dly_t drop_dly,
	input wire logic clear_count,
	// Measured voltage in millivolts
	input wire dio_pkg::mv_t meas_mv,
	// Conditioned result
	output logic status,
	output dio_pkg::cnt_t count
);

	dio_pkg::chan_state_t q, d;
	dio_pkg::mv_t act_mv;
	dio_pkg::mv_t rel_mv;
	dio_pkg::elapsed_t need;

	// AC mode swaps the user release level for a tenth of activation
	assign act_mv = dio_pkg::thr_to_mv(act_thr);
	assign rel_mv = ac_mode ? act_mv / dio_pkg::mv_t'(`DIO_AC_REL_DIV)
		: dio_pkg::thr_to_mv(rel_thr);

	// Hold time for the pending change; AC adds ride-through on drop
	assign need = q.raw ? {1'b0, act_dly}
		: {1'b0, drop_dly} + (ac_mode ? dio_pkg::elapsed_t'(`DIO_AC_DROP_MS)
		: '0);

	always_comb begin
		d = q;
		// Measure once per scan; between the levels nothing changes
		if (scan_tick) begin
			if (meas_mv > act_mv) begin
				d.energized = 1'b1;
			end else if (meas_mv < rel_mv) begin
				d.energized = 1'b0;
			end
			d.raw = d.energized ^ energized_inactive;
		end
		// Time a pending change in whole milliseconds, saturating
		if (q.raw == q.status) begin
			d.elapsed = '0;
		end else if (ms_tick && q.elapsed != '1) begin
			d.elapsed = q.elapsed + dio_pkg::elapsed_t'(1);
		end
		// Clear first, so a rise in the same cycle still counts
		if (clear_count) begin
			d.count = '0;
		end
		// Report only at a scan, once the hold time is served
		if (scan_tick && q.raw != q.status && q.elapsed >= need) begin
			d.status = q.raw;
			d.elapsed = '0;
			if (q.raw) begin
				d.count = d.count + dio_pkg::cnt_t'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign status = q.status;
	assign count = q.count;

endmodule

// ### digital_io_conditioning.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module digital_io_conditioning #(
	parameter int unsigned MS_CYCLES = `DIO_MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// AXI4-Lite write address
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Measurement front end, same clock domain
	input wire logic [`DIO_NUM_IN-1:0][`DIO_MV_W-1:0] meas_mv,
	// Conditioned inputs and relay drive
	output logic [`DIO_NUM_IN-1:0] input_chan_n,
	output logic [`DIO_NUM_RELAY-1:0] relay_chan_n
);

	dio_pkg::regs_t q, d;
	logic ms_tick;
	logic scan_tick;
	logic [`DIO_NUM_IN-1:0] chan_status;
	logic [`DIO_NUM_IN-1:0][`DIO_CNT_W-1:0] chan_count;
	logic [31:0] wr_merged;
	logic [31:0] rd_word;
	logic [2:0] wch;

	// Byte-lane merge of a write into the current word
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = cur;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// True when the address names a register
	function automatic logic addr_ok(input logic [11:0] a);
		logic ok;
		ok = 1'b0;
		if (a[11:8] == `DIO_CH_PAGE) begin
			ok = (a[4:2] <= `DIO_CH_VOLT);
		end else begin
			ok = ({a[11:2], 2'b00} == `DIO_RELAY_OFS) || ({a[11:2], 2'b00} == `DIO_STATUS_OFS)
				|| ({a[11:2], 2'b00} == `DIO_CLEAR_OFS);
		end
		return ok;
	endfunction

	// Word seen by a read at an address; also the base for a write merge
	function automatic logic [31:0] read_word(input logic [11:0] a, input dio_pkg::regs_t r,
		input logic [`DIO_NUM_IN-1:0] st,
		input logic [`DIO_NUM_IN-1:0][`DIO_CNT_W-1:0] cnt,
		input logic [`DIO_NUM_IN-1:0][`DIO_MV_W-1:0] mv);
		logic [31:0] v;
		logic [2:0] c;
		v = 32'h0;
		c = a[7:5];
		if (a[11:8] == `DIO_CH_PAGE) begin
			case (a[4:2])
				`DIO_CH_CFG: v = {30'h0, r.ac[c], r.pol[c]};
				`DIO_CH_ACT: v = {20'h0, r.act_thr[c]};
				`DIO_CH_REL: v = {20'h0, r.rel_thr[c]};
				`DIO_CH_ADLY: v = {11'h0, r.act_dly[c]};
				`DIO_CH_DDLY: v = {11'h0, r.drop_dly[c]};
				`DIO_CH_CNT: v = cnt[c];
				`DIO_CH_VOLT: v = {13'h0, mv[c]};
				default: v = 32'h0;
			endcase
		end else begin
			case ({a[11:2], 2'b00})
				`DIO_RELAY_OFS: v = {27'h0, r.relay_cmd};
				`DIO_STATUS_OFS: v = {24'h0, st};
				default: v = 32'h0;
			endcase
		end
		return v;
	endfunction

	// Millisecond and scan ticks
	scan_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.ms_tick(ms_tick),
		.scan_tick(scan_tick)
	);

	// One conditioner per input channel
	for (genvar n = 0; n < `DIO_NUM_IN; n++) begin : g_chan
		input_channel_cond u_chan (
			.clk_sys(clk_sys),
			.reset(reset),
			.ms_tick(ms_tick),
			.scan_tick(scan_tick),
			.energized_inactive(q.pol[n]),
			.ac_mode(q.ac[n]),
			.act_thr(q.act_thr[n]),
			.rel_thr(q.rel_thr[n]),
			.act_dly(q.act_dly[n]),
			.drop_dly(q.drop_dly[n]),
			.clear_count(q.clear[n]),
			.meas_mv(meas_mv[n]),
			.status(chan_status[n]),
			.count(chan_count[n])
		);
	end

	// Write merge and read fetch share one decoder
	assign wr_merged = merge(read_word(q.awaddr, q, chan_status, chan_count, meas_mv),
		q.wdata, q.wstrb);
	assign rd_word = read_word(araddr, q, chan_status, chan_count, meas_mv);
	assign wch = q.awaddr[7:5];

	// Bus slave, settings and relay refresh
	always_comb begin
		d = q;
		d.clear = '0;
		// Address and data are taken independently, in either order
		if (awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = awaddr;
		end
		if (wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = wdata;
			d.wstrb = wstrb;
		end
		unique case (q.wr)
			dio_pkg::WR_COLLECT: begin
				if (q.aw_have && q.w_have) begin
					d.bresp = addr_ok(q.awaddr) ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
					if (q.awaddr[11:8] == `DIO_CH_PAGE) begin
						case (q.awaddr[4:2])
							`DIO_CH_CFG: begin
								d.pol[wch] = wr_merged[`DIO_CFG_POL_BIT];
								d.ac[wch] = wr_merged[`DIO_CFG_AC_BIT];
							end
							`DIO_CH_ACT: d.act_thr[wch] = wr_merged[`DIO_THR_W-1:0];
							`DIO_CH_REL: d.rel_thr[wch] = wr_merged[`DIO_THR_W-1:0];
							`DIO_CH_ADLY: d.act_dly[wch] = wr_merged[`DIO_DLY_W-1:0];
							`DIO_CH_DDLY: d.drop_dly[wch] = wr_merged[`DIO_DLY_W-1:0];
							default: d.bresp = q.awaddr[4:2] <= `DIO_CH_VOLT ? `DIO_RESP_OKAY
								: `DIO_RESP_SLVERR;
						endcase
					end else if ({q.awaddr[11:2], 2'b00} == `DIO_RELAY_OFS) begin
						d.relay_cmd = wr_merged[`DIO_NUM_RELAY-1:0];
					end else if ({q.awaddr[11:2], 2'b00} == `DIO_CLEAR_OFS) begin
						// Strobe only; the word reads back as zero
						d.clear = q.wdata[`DIO_NUM_IN-1:0]
							& {`DIO_NUM_IN{q.wstrb[0]}};
					end
					d.bvalid = 1'b1;
					d.wr = dio_pkg::WR_RESP;
				end
			end
			dio_pkg::WR_RESP: begin
				if (bready) begin
					d.bvalid = 1'b0;
					d.aw_have = 1'b0;
					d.w_have = 1'b0;
					d.wr = dio_pkg::WR_COLLECT;
				end
			end
		endcase
		// Ready only while the holding slot is free
		d.awready = !d.aw_have;
		d.wready = !d.w_have;
		// Reads: one outstanding, data captured at the address handshake
		unique case (q.rd)
			dio_pkg::RD_IDLE: begin
				if (arvalid && q.arready) begin
					d.rdata = rd_word;
					d.rresp = addr_ok(araddr) ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
					d.rvalid = 1'b1;
					d.arready = 1'b0;
					d.rd = dio_pkg::RD_DATA;
				end
			end
			dio_pkg::RD_DATA: begin
				if (rready) begin
					d.rvalid = 1'b0;
					d.arready = 1'b1;
					d.rd = dio_pkg::RD_IDLE;
				end
			end
		endcase
		// Relays follow software only at the scan, so all switch together
		if (scan_tick) begin
			d.relay_out = q.relay_cmd;
		end
	end

	// Settings start at their documented defaults
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
			q.wr <= dio_pkg::WR_COLLECT;
			q.rd <= dio_pkg::RD_IDLE;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			q.act_thr <= {`DIO_NUM_IN{`DIO_ACT_THR_RST}};
			q.rel_thr <= {`DIO_NUM_IN{`DIO_REL_THR_RST}};
			q.act_dly <= {`DIO_NUM_IN{`DIO_DLY_RST}};
			q.drop_dly <= {`DIO_NUM_IN{`DIO_DLY_RST}};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from registers
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign input_chan_n = chan_status;
	assign relay_chan_n = q.relay_out;

endmodule

// ### dio_chk_sva.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module dio_chk #(
	parameter int unsigned MS_CYCLES = 4
) (
	// Clock and reset
	input logic clk_sys,
	input logic reset,
	// Bus handshakes
	input logic awvalid,
	input logic awready,
	input logic wvalid,
	input logic wready,
	input logic [1:0] bresp,
	input logic bvalid,
	input logic bready,
	input logic arvalid,
	input logic arready,
	input logic [31:0] rdata,
	input logic rvalid,
	input logic rready,
	// Conditioned outputs
	input logic [`DIO_NUM_IN-1:0] input_chan_n,
	input logic [`DIO_NUM_RELAY-1:0] relay_chan_n
);
	localparam int unsigned SCAN = 5 * MS_CYCLES;
	logic [31:0] in_gap_q;
	logic [31:0] rl_gap_q;
	logic in_seen_q;
	logic rl_seen_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Gap since each output last moved; scan ticks are the only legal moments
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			in_gap_q <= 32'h0;
			rl_gap_q <= 32'h0;
			in_seen_q <= 1'b0;
			rl_seen_q <= 1'b0;
		end else begin
			in_gap_q <= $changed(input_chan_n) ? 32'h1 : in_gap_q + 32'h1;
			rl_gap_q <= $changed(relay_chan_n) ? 32'h1 : rl_gap_q + 32'h1;
			in_seen_q <= in_seen_q | $changed(input_chan_n);
			rl_seen_q <= rl_seen_q | $changed(relay_chan_n);
		end
	end

	property p_in_scan;
		in_seen_q && $changed(input_chan_n) |-> (in_gap_q % SCAN) == 0;
	endproperty
	a_in_scan: assert property (p_in_scan) else $error("input moved off scan");
	property p_rl_scan;
		rl_seen_q && $changed(relay_chan_n) |-> (rl_gap_q % SCAN) == 0;
	endproperty
	a_rl_scan: assert property (p_rl_scan) else $error("relay moved off scan");
	property p_rst_out;
		disable iff (1'b0) reset |=> relay_chan_n == '0 && input_chan_n == '0;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
	property p_b_lat;
		awvalid && awready && wvalid && wready |-> ##2 bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_lat;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_busy;
		bvalid |-> !awready && !wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("write taken while answer pends");
endmodule

bind digital_io_conditioning dio_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.clk_sys(clk_sys), .reset(reset), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
	.rready(rready), .input_chan_n(input_chan_n), .relay_chan_n(relay_chan_n));

// ### meas_front_end.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module meas_front_end (
	// Clock and reset
	input logic clk_sys,
	input logic reset,
	// Voltage applied at each channel, mV
	input logic [`DIO_NUM_IN-1:0][`DIO_MV_W-1:0] set_mv,
	// Converted channel voltage
	output logic [`DIO_NUM_IN-1:0][`DIO_MV_W-1:0] meas_mv
);
	// One conversion per clock, so the block sees a step one cycle late
	always_ff @(posedge clk_sys) begin
		meas_mv <= reset ? '0 : set_mv;
	end
endmodule

// ### tb_digital_io_conditioning.sv
`timescale 1ns/100ps
`include "dio_params.svh"

module tb_digital_io_conditioning;
	localparam int unsigned MSC = 4;
	localparam int SCAN = 5 * MSC;
	logic clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [1:0] b_last;
	logic [`DIO_NUM_IN-1:0][`DIO_MV_W-1:0] set_mv, meas_mv;
	logic [`DIO_NUM_IN-1:0] input_chan_n;
	logic [`DIO_NUM_RELAY-1:0] relay_chan_n;
	int err_total, n_compared, cyc;

	digital_io_conditioning #(.MS_CYCLES(MSC)) dut (.clk_sys(clk_sys), .reset(reset),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.meas_mv(meas_mv), .input_chan_n(input_chan_n), .relay_chan_n(relay_chan_n));
	meas_front_end fe (.clk_sys(clk_sys), .reset(reset), .set_mv(set_mv),
		.meas_mv(meas_mv));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard, well above the expected run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Bus write; the answer is accepted a cycle late to exercise its hold
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_sys);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge clk_sys);
		bready <= 1'b1;
		@(posedge clk_sys);
		b_last = bresp;
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Bus read
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk_sys);
		rready <= 1'b1;
		@(posedge clk_sys);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, d, e);
	endtask

	function automatic logic [11:0] ca(input int ch, input logic [11:0] off);
		return 12'h100 + (12'(ch) << 5) + off;
	endfunction

	// Two scans plus margin: sampling scan, then the update scan
	task automatic settle();
		repeat (2 * SCAN + 4) @(posedge clk_sys);
	endtask

	task automatic t_defaults();
		rc("cfg", ca(7, 12'h000), 32'h0);
		rc("act", ca(7, 12'h004), 32'h370);
		rc("rel", ca(7, 12'h008), 32'h258);
		rc("adly", ca(7, 12'h00C), 32'h0);
		rc("ddly", ca(7, 12'h010), 32'h0);
		rc("cnt", ca(7, 12'h014), 32'h0);
	endtask

	// Rise, hysteresis band, fall, second rise, then counter clear
	task automatic t_thresh();
		set_mv[0] <= 19'h15F90;
		settle();
		chk("on", {31'h0, input_chan_n[0]}, 32'h1);
		rc("volt", ca(0, 12'h018), 32'h15F90);
		set_mv[0] <= 19'h11170;
		settle();
		chk("band", {31'h0, input_chan_n[0]}, 32'h1);
		set_mv[0] <= 19'h0C350;
		settle();
		chk("off", {31'h0, input_chan_n[0]}, 32'h0);
		set_mv[0] <= 19'h15F90;
		settle();
		rc("cnt", ca(0, 12'h014), 32'h2);
		wr(12'h008, 32'h1);
		rc("clr", ca(0, 12'h014), 32'h0);
	endtask

	task automatic t_pol();
		wr(ca(1, 12'h000), 32'h1);
		settle();
		chk("inv lo", {31'h0, input_chan_n[1]}, 32'h1);
		set_mv[1] <= 19'h15F90;
		settle();
		chk("inv hi", {31'h0, input_chan_n[1]}, 32'h0);
	endtask

	// Same voltage, channel 2 on a 10 V threshold, channel 3 on default
	task automatic t_per_ch();
		wr(ca(2, 12'h004), 32'h64);
		set_mv[2] <= 19'h04E20;
		set_mv[3] <= 19'h04E20;
		settle();
		chk("per ch", {30'h0, input_chan_n[3:2]}, 32'h1);
	endtask

	// 12 ms each way is more than two scans
	task automatic t_delay();
		wr(ca(4, 12'h00C), 32'hC);
		wr(ca(4, 12'h010), 32'hC);
		set_mv[4] <= 19'h15F90;
		settle();
		chk("rise early", {31'h0, input_chan_n[4]}, 32'h0);
		repeat (3 * SCAN) @(posedge clk_sys);
		chk("rise late", {31'h0, input_chan_n[4]}, 32'h1);
		set_mv[4] <= 19'h0;
		settle();
		chk("drop early", {31'h0, input_chan_n[4]}, 32'h1);
		repeat (3 * SCAN) @(posedge clk_sys);
		chk("drop late", {31'h0, input_chan_n[4]}, 32'h0);
	endtask

	// AC release is 8.8 V, and the fall waits 30 ms
	task automatic t_ac();
		wr(ca(5, 12'h000), 32'h2);
		set_mv[5] <= 19'h15F90;
		settle();
		set_mv[5] <= 19'h0C350;
		settle();
		chk("ac band", {31'h0, input_chan_n[5]}, 32'h1);
		set_mv[5] <= 19'h0;
		settle();
		chk("ac hold", {31'h0, input_chan_n[5]}, 32'h1);
		repeat (6 * SCAN) @(posedge clk_sys);
		chk("ac drop", {31'h0, input_chan_n[5]}, 32'h0);
		// Every channel kept its own result: 0 and 2 high, the rest low
		chk("all in", {24'h0, input_chan_n}, 32'h05);
		rc("status", 12'h004, 32'h05);
	endtask

	task automatic t_relay();
		logic [4:0] v[2] = '{5'h15, 5'h0A};
		logic [31:0] d;
		logic [1:0] r;
		foreach (v[i]) begin
			wr(12'h000, {27'h0, v[i]});
			chk("wr resp", {30'h0, b_last}, 32'h0);
			repeat (SCAN + 2) @(posedge clk_sys);
			chk("relay", {27'h0, relay_chan_n}, {27'h0, v[i]});
			rc("relay reg", 12'h000, {27'h0, v[i]});
		end
		rd(ca(0, 12'h01C), d, r);
		chk("hole data", d, 32'h0);
		chk("hole resp", {30'h0, r}, 32'h2);
		wr(ca(0, 12'h01C), 32'h1);
		chk("hole wr resp", {30'h0, b_last}, 32'h2);
	endtask

	// Time-zero values, reset, scenarios
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		set_mv = '0;
		{err_total, n_compared, cyc} = '0;
		reset = 1'b1;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_defaults();
		t_thresh();
		t_pol();
		t_per_ch();
		t_delay();
		t_ac();
		t_relay();
		give_verdict();
	end
endmodule
